/* hw/crtcv_core.sv */
// Purpose: Vertical timing, refresh address and cursor for a CRT controller
// Assumes: sys_clk_i is the character clock; hretrace_i pulses once a line
// Notes: Horizontal timing and cursor rows come from elsewhere
module crtcv_core (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic hretrace_i,
  input wire logic hdisp_i,
  input wire logic alpha_mode_i,
  input wire logic cursor_row_i,
  output logic [15:0] mem_addr_o,
  output logic vsync_o,
  output logic vblank_o,
  output logic vdisp_o,
  output logic cursor_o,
  output logic underline_o,
  output logic irq_o
);
  import crtcv_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [7:0] overflow_reg, max_scan, cursor_end, start_address_middle;
  logic [7:0] start_address_low, cursor_location_high, cursor_location_low;
  logic [7:0] vertical_retrace_start, vertical_retrace_end_ctrl;
  logic [7:0] vertical_display_end, line_offset, underline_row;
  logic [7:0] vertical_blank_start, vertical_blank_end, crtc_mode_control;
  logic [7:0] address_extension_reg, vertical_extension_reg;
  logic [7:0] vtotal_lo, vtotal_hi;
  logic [7:0] next_rdata;
  logic irq_req, next_irq_req;

  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] o);
    return reg_wr_i && (a == o);
  endfunction

  // Protected timing registers 0-7 live elsewhere except overflow
  logic prot;
  assign prot = vertical_retrace_end_ctrl[VRE_PROTECT];

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      overflow_reg <= REG_RESET;
      max_scan <= REG_RESET;
      cursor_end <= REG_RESET;
      start_address_middle <= REG_RESET;
      start_address_low <= REG_RESET;
      cursor_location_high <= REG_RESET;
      cursor_location_low <= REG_RESET;
      vertical_retrace_start <= REG_RESET;
      vertical_retrace_end_ctrl <= REG_RESET;
      vertical_display_end <= REG_RESET;
      line_offset <= REG_RESET;
      underline_row <= REG_RESET;
      vertical_blank_start <= REG_RESET;
      vertical_blank_end <= REG_RESET;
      crtc_mode_control <= REG_RESET;
      address_extension_reg <= REG_RESET;
      vertical_extension_reg <= REG_RESET;
      vtotal_lo <= REG_RESET;
      vtotal_hi <= REG_RESET;
    end else begin
      if (wr_hit(reg_addr_i, OFS_OVERFLOW)) begin
        if (prot) begin
          overflow_reg[4] <= reg_wdata_i[4];
        end else begin
          overflow_reg <= reg_wdata_i;
        end
      end
      if (wr_hit(reg_addr_i, OFS_MAX_SCAN)) max_scan <= reg_wdata_i;
      if (wr_hit(reg_addr_i, OFS_CURSOR_END))
        cursor_end <= reg_wdata_i & CE_MASK;
      if (wr_hit(reg_addr_i, OFS_START_MID))
        start_address_middle <= reg_wdata_i;
      if (wr_hit(reg_addr_i, OFS_START_LOW)) start_address_low <= reg_wdata_i;
      if (wr_hit(reg_addr_i, OFS_CURSOR_HIGH))
        cursor_location_high <= reg_wdata_i;
      if (wr_hit(reg_addr_i, OFS_CURSOR_LOW))
        cursor_location_low <= reg_wdata_i;
      if (wr_hit(reg_addr_i, OFS_VSYNC_START))
        vertical_retrace_start <= reg_wdata_i;
      if (wr_hit(reg_addr_i, OFS_VSYNC_END))
        vertical_retrace_end_ctrl <= reg_wdata_i;
      if (wr_hit(reg_addr_i, OFS_VDISP_END))
        vertical_display_end <= reg_wdata_i;
      if (wr_hit(reg_addr_i, OFS_LINE_OFFSET)) line_offset <= reg_wdata_i;
      if (wr_hit(reg_addr_i, OFS_UNDERLINE))
        underline_row <= reg_wdata_i & UL_MASK;
      if (wr_hit(reg_addr_i, OFS_VBLANK_START))
        vertical_blank_start <= reg_wdata_i;
      if (wr_hit(reg_addr_i, OFS_VBLANK_END))
        vertical_blank_end <= reg_wdata_i;
      if (wr_hit(reg_addr_i, OFS_MODE_CTRL))
        crtc_mode_control <= reg_wdata_i & MC_MASK;
      if (wr_hit(reg_addr_i, OFS_ADDR_EXT))
        address_extension_reg <= reg_wdata_i & 8'hBF;
      if (wr_hit(reg_addr_i, OFS_VERT_EXT))
        vertical_extension_reg <= reg_wdata_i;
      if (wr_hit(reg_addr_i, OFS_VTOTAL)) vtotal_lo <= reg_wdata_i;
      if (wr_hit(reg_addr_i, OFS_VTOTAL_HI)) vtotal_hi <= reg_wdata_i & 8'h0F;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assembled vertical values
  logic [11:0] vtotal, vsync_start, vblank_start;
  logic [10:0] vdisp_end;
  logic [19:0] start_addr;
  logic [9:0] row_offset;
  logic [15:0] cursor_loc;
  assign vtotal = {vtotal_hi[3:0], vtotal_lo};
  assign vsync_start = {vertical_extension_reg[6:5], overflow_reg[7],
                        overflow_reg[2], vertical_retrace_start};
  assign vblank_start = {vertical_extension_reg[4:3], max_scan[5],
                         overflow_reg[3], vertical_blank_start};
  assign vdisp_end = {vertical_extension_reg[2], overflow_reg[6],
                      overflow_reg[1], vertical_display_end};
  assign start_addr = {address_extension_reg[3:0], start_address_middle,
                       start_address_low};
  assign row_offset = {address_extension_reg[5:4], line_offset};
  assign cursor_loc = {cursor_location_high, cursor_location_low};

  ////////////////////////////////////////////////////////////////////////
  // Line, row and address counters
  logic [11:0] vcount, next_vcount;
  logic half_line, next_half_line;
  logic [4:0] row, next_row;
  logic [19:0] row_start, next_row_start, addr_cnt, next_addr_cnt;
  logic [1:0] div_cnt, next_div_cnt;
  logic vsync_q, next_vsync, vblank_q, next_vblank, vdisp_q, next_vdisp;
  logic line_tick, frame_end, div4, div2, addr_tick, dword_md;

  assign div4 = underline_row[UL_DIV4];
  assign div2 = crtc_mode_control[MC_DIV2];
  assign dword_md = underline_row[UL_DWORD];
  // Half-rate stepping doubles every vertical unit
  assign line_tick = hretrace_i &&
    (!crtc_mode_control[MC_HSEL] || half_line);
  assign frame_end = line_tick && (vcount == vtotal);
  assign addr_tick = div2 ? (div_cnt[0] == 1'b1) :
                     div4 ? (div_cnt == 2'h3) : 1'b1;

  always_comb begin
    next_half_line = half_line;
    next_vcount = vcount;
    next_row = row;
    next_row_start = row_start;
    next_addr_cnt = addr_cnt;
    next_div_cnt = div_cnt;
    next_vsync = vsync_q;
    next_vblank = vblank_q;
    next_vdisp = vdisp_q;
    if (hretrace_i) next_half_line = ~half_line;
    if (hdisp_i) begin
      next_div_cnt = div_cnt + 2'h1;
      if (addr_tick) next_addr_cnt = addr_cnt + 20'h1;
    end
    if (line_tick) begin
      next_vcount = vcount + 12'h1;
      if (row == max_scan[4:0]) begin
        next_row = 5'h00;
        // Offset unit is four in dword form, two in both word and byte form
        next_row_start = row_start + (dword_md ?
          {8'h00, row_offset, 2'b00} : {9'h000, row_offset, 1'b0});
      end else begin
        next_row = row + 5'h01;
      end
      next_addr_cnt = next_row_start;
      next_div_cnt = 2'h0;
      if (next_vcount == vsync_start) next_vsync = 1'b1;
      else if (vsync_q && next_vcount[3:0] == vertical_retrace_end_ctrl[3:0])
        next_vsync = 1'b0;
      if (next_vcount == vblank_start) next_vblank = 1'b1;
      else if (vblank_q && next_vcount[7:0] == vertical_blank_end)
        next_vblank = 1'b0;
      if (next_vcount == {1'b0, vdisp_end}) next_vdisp = 1'b0;
    end
    if (frame_end) begin
      next_vcount = 12'h000;
      next_row = 5'h00;
      next_row_start = start_addr;
      next_addr_cnt = start_addr;
      next_vdisp = 1'b1;
      next_half_line = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      half_line <= 1'b0;
      vcount <= 12'h000;
      row <= 5'h00;
      row_start <= 20'h00000;
      addr_cnt <= 20'h00000;
      div_cnt <= 2'h0;
      vsync_q <= 1'b0;
      vblank_q <= 1'b0;
      vdisp_q <= 1'b1;
    end else begin
      half_line <= next_half_line;
      vcount <= next_vcount;
      row <= next_row;
      row_start <= next_row_start;
      addr_cnt <= next_addr_cnt;
      div_cnt <= next_div_cnt;
      vsync_q <= next_vsync;
      vblank_q <= next_vblank;
      vdisp_q <= next_vdisp;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Memory address mapping
  logic [15:0] next_ma;
  logic cms, rsel, wrap;
  assign cms = crtc_mode_control[MC_CMS];
  assign rsel = crtc_mode_control[MC_ROWSEL];
  assign wrap = crtc_mode_control[MC_ADDWRAP];

  always_comb begin
    if (dword_md) begin
      next_ma = {addr_cnt[13], rsel ? addr_cnt[12] : row[1],
                 cms ? addr_cnt[11] : row[0], addr_cnt[10:0], 2'b00};
    end else if (!crtc_mode_control[MC_WBMODE]) begin
      next_ma = {addr_cnt[14], rsel ? addr_cnt[13] : row[1],
                 cms ? addr_cnt[12] : row[0], addr_cnt[11:0],
                 wrap ? addr_cnt[15] : addr_cnt[13]};
    end else begin
      next_ma = {addr_cnt[15], rsel ? addr_cnt[14] : row[1],
                 cms ? addr_cnt[13] : row[0], addr_cnt[12:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Cursor skew, underline and interrupt
  logic [3:0] cur_pipe, next_cur_pipe;
  logic cur_hit, next_ul, next_irq, vsync_rise;
  logic clr_wr;
  assign cur_hit = alpha_mode_i && cursor_row_i && hdisp_i &&
                   (addr_cnt[15:0] == cursor_loc);
  assign vsync_rise = next_vsync && !vsync_q;
  // Request cleared while the clear bit is held low
  assign clr_wr = !vertical_retrace_end_ctrl[VRE_INT_CLR];

  always_comb begin
    next_cur_pipe = {cur_pipe[2:0], cur_hit};
    next_ul = vdisp_q && hdisp_i && (row == underline_row[4:0]);
    // A new retrace wins over a pending clear
    next_irq_req = vsync_rise ? 1'b1 : (clr_wr ? 1'b0 : irq_req);
    next_irq = irq_req && vertical_retrace_end_ctrl[VRE_INT_EN];
    next_rdata = 8'h00;
    case (reg_addr_i)
      OFS_OVERFLOW: next_rdata = overflow_reg;
      OFS_MAX_SCAN: next_rdata = max_scan;
      OFS_CURSOR_END: next_rdata = cursor_end;
      OFS_START_MID: next_rdata = start_address_middle;
      OFS_START_LOW: next_rdata = start_address_low;
      OFS_CURSOR_HIGH: next_rdata = cursor_location_high;
      OFS_CURSOR_LOW: next_rdata = cursor_location_low;
      OFS_VSYNC_START: next_rdata = vertical_retrace_start;
      OFS_VSYNC_END: next_rdata = vertical_retrace_end_ctrl;
      OFS_VDISP_END: next_rdata = vertical_display_end;
      OFS_LINE_OFFSET: next_rdata = line_offset;
      OFS_UNDERLINE: next_rdata = underline_row;
      OFS_VBLANK_START: next_rdata = vertical_blank_start;
      OFS_VBLANK_END: next_rdata = vertical_blank_end;
      OFS_MODE_CTRL: next_rdata = crtc_mode_control;
      OFS_ADDR_EXT: next_rdata = address_extension_reg;
      OFS_VERT_EXT: next_rdata = vertical_extension_reg;
      OFS_STATUS: next_rdata = {4'h0, irq_req, vdisp_q, vblank_q, vsync_q};
      OFS_VTOTAL: next_rdata = vtotal_lo;
      OFS_VTOTAL_HI: next_rdata = vtotal_hi;
      default: next_rdata = 8'h00;
    endcase
    if (!reg_rd_i) next_rdata = 8'h00;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cur_pipe <= 4'h0;
      underline_o <= 1'b0;
      irq_req <= 1'b0;
      irq_o <= 1'b0;
      reg_rdata_o <= 8'h00;
      mem_addr_o <= 16'h0000;
    end else begin
      cur_pipe <= next_cur_pipe;
      underline_o <= next_ul;
      irq_req <= next_irq_req;
      irq_o <= next_irq;
      reg_rdata_o <= next_rdata;
      mem_addr_o <= next_ma;
    end
  end

  always_comb begin
    case (cursor_end[6:5])
      2'b00: cursor_o = cur_pipe[0];
      2'b01: cursor_o = cur_pipe[1];
      2'b10: cursor_o = cur_pipe[2];
      default: cursor_o = cur_pipe[3];
    endcase
  end

  assign vsync_o = vsync_q;
  assign vblank_o = vblank_q;
  assign vdisp_o = vdisp_q;

  ////////////////////////////////////////////////////////////////////////
  a_protect_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (reg_wr_i && reg_addr_i == OFS_OVERFLOW && prot) |=>
      ({overflow_reg[7:5], overflow_reg[3:0]} ==
       $past({overflow_reg[7:5], overflow_reg[3:0]})))
    else $error("protected overflow bits changed");
  a_reserved_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !underline_row[7] && !cursor_end[7])
    else $error("reserved bit set");
  a_irq_gate: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (irq_req && vertical_retrace_end_ctrl[VRE_INT_EN]) |=> irq_o)
    else $error("interrupt not raised");
  a_irq_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (clr_wr && !vsync_rise) |=> !irq_req)
    else $error("request not cleared");
  a_frame_load: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    frame_end |=> (addr_cnt == $past(start_addr)))
    else $error("start address not loaded");
  a_vsync_end: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $fell(vsync_q) |-> (vcount[3:0] == vertical_retrace_end_ctrl[3:0]))
    else $error("vsync ended on wrong line");
  a_vblank_end: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $fell(vblank_q) |-> (vcount[7:0] == vertical_blank_end))
    else $error("vblank ended on wrong line");
  a_dword_low: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $past(dword_md) |-> (mem_addr_o[1:0] == 2'b00))
    else $error("dword low bits not zero");
  a_div_hold: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (hdisp_i && !addr_tick && !line_tick) |=> (addr_cnt == $past(addr_cnt)))
    else $error("address counter stepped off its divided clock");
  a_half_rate: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (hretrace_i && crtc_mode_control[MC_HSEL] && !half_line) |=>
      (vcount == $past(vcount)))
    else $error("line counter stepped on a skipped retrace");
  a_ul_display: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    !vdisp_q |=> !underline_o)
    else $error("underline outside display");
endmodule : crtcv_core

/* hw/crtcv_pkg.sv */
// Purpose: Constants for the CRTC vertical timing and address generator
// Assumes: Byte-wide indexed registers, character clock as system clock
// Notes: Register index equals byte address on the plain register port
package crtcv_pkg;
  // Register offsets
  localparam logic [7:0] OFS_OVERFLOW = 8'h07;
  localparam logic [7:0] OFS_MAX_SCAN = 8'h09;
  localparam logic [7:0] OFS_CURSOR_END = 8'h0B;
  localparam logic [7:0] OFS_START_MID = 8'h0C;
  localparam logic [7:0] OFS_START_LOW = 8'h0D;
  localparam logic [7:0] OFS_CURSOR_HIGH = 8'h0E;
  localparam logic [7:0] OFS_CURSOR_LOW = 8'h0F;
  localparam logic [7:0] OFS_VSYNC_START = 8'h10;
  localparam logic [7:0] OFS_VSYNC_END = 8'h11;
  localparam logic [7:0] OFS_VDISP_END = 8'h12;
  localparam logic [7:0] OFS_LINE_OFFSET = 8'h13;
  localparam logic [7:0] OFS_UNDERLINE = 8'h14;
  localparam logic [7:0] OFS_VBLANK_START = 8'h15;
  localparam logic [7:0] OFS_VBLANK_END = 8'h16;
  localparam logic [7:0] OFS_MODE_CTRL = 8'h17;
  localparam logic [7:0] OFS_ADDR_EXT = 8'h40;
  localparam logic [7:0] OFS_VERT_EXT = 8'h42;
  localparam logic [7:0] OFS_STATUS = 8'h48;
  localparam logic [7:0] OFS_VTOTAL = 8'h49;
  localparam logic [7:0] OFS_VTOTAL_HI = 8'h4A;
  localparam logic [7:0] PROT_LAST = 8'h07;
  // Field positions
  localparam int VRE_PROTECT = 7;
  localparam int VRE_INT_EN = 5;
  localparam int VRE_INT_CLR = 4;
  localparam int UL_DWORD = 6;
  localparam int UL_DIV4 = 5;
  localparam int MC_WBMODE = 6;
  localparam int MC_ADDWRAP = 5;
  localparam int MC_DIV2 = 3;
  localparam int MC_HSEL = 2;
  localparam int MC_ROWSEL = 1;
  localparam int MC_CMS = 0;
  // Read masks for reserved bits
  localparam logic [7:0] UL_MASK = 8'h7F;
  localparam logic [7:0] CE_MASK = 8'h7F;
  localparam logic [7:0] MC_MASK = 8'hEF;
  localparam logic [7:0] REG_RESET = 8'h00;
endpackage : crtcv_pkg

/* verif/crtcv_core_bench.sv */
// Purpose: Self-checking bench for the vertical timing and address block
// Assumes: Line of 16 character clocks, display memory never stalls
// Notes: Start address 0x6538 fixed for all address map rows
module crtcv_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import crtcv_pkg::*;

  logic sys_clk_i, rst_i, reg_wr_i, reg_rd_i, hretrace_i;
  logic hdisp_i, alpha_mode_i, cursor_row_i;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, rv;
  logic [15:0] mem_addr_o, fetch_addr;
  logic vsync_o, vblank_o, vdisp_o, cursor_o, underline_o, irq_o;
  logic [3:0] hcnt;
  logic hen;
  int error_cnt, n_tests, cursor_hits;
  // Rows: underline reg, mode reg, expected refresh address
  localparam logic [31:0] MAPS [7] = '{32'h00436538, 32'h00400538,
    32'h0003CA71, 32'h0023CA70, 32'h00008A71, 32'h404394E0, 32'h400394E0};
  localparam logic [15:0] FRAME_CFG [7] = '{16'h4909, 16'h1205, 16'h1506,
    16'h1608, 16'h1007, 16'h1138, 16'h1743};
  localparam logic [7:0] RSV_OFS [3] = '{OFS_CURSOR_END, OFS_UNDERLINE,
    OFS_MODE_CTRL};
  localparam logic [7:0] RSV_MASK [3] = '{CE_MASK, UL_MASK, MC_MASK};
  // Rows: underline reg, mode reg, column 14 address of lines 0 and 1
  localparam logic [47:0] HROWS [5] = '{48'h0043_6540_6560,
    48'h014B_653C_655C, 48'h2043_653A_655A, 48'h204B_653C_655C,
    48'h4043_9500_9600};

  crtcv_core uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .hretrace_i(hretrace_i), .hdisp_i(hdisp_i),
    .alpha_mode_i(alpha_mode_i), .cursor_row_i(cursor_row_i),
    .mem_addr_o(mem_addr_o), .vsync_o(vsync_o), .vblank_o(vblank_o),
    .vdisp_o(vdisp_o), .cursor_o(cursor_o), .underline_o(underline_o),
    .irq_o(irq_o));

  crtcv_mem_model mem (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .mem_addr_i(mem_addr_o), .fetch_addr_o(fetch_addr));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  // Horizontal side stand-in: one retrace pulse per 16 clocks
  always @(posedge sys_clk_i) begin
    hcnt <= hcnt + 4'h1;
    hretrace_i <= (hcnt == 4'hF);
    // Active window covers columns 4 to 11 of each line
    hdisp_i <= hen && (hcnt >= 4'h3) && (hcnt <= 4'hA);
    if (!rst_i && cursor_o === 1'b1) begin
      cursor_hits <= cursor_hits + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Waits for display enable to rise, which opens line 0 of a frame
  task automatic frame_sync();
    int k;
    k = 0;
    while (vdisp_o !== 1'b0 && k < 800) begin
      @(posedge sys_clk_i);
      #1 k++;
    end
    while (vdisp_o !== 1'b1 && k < 800) begin
      @(posedge sys_clk_i);
      #1 k++;
    end
    if (k >= 800) begin
      error_cnt++;
      $display("[ERR] frame start expected rise seen none");
      print_verdict();
    end
  endtask

  // Steps at least one edge, then on to the given column
  task automatic at_col(input logic [3:0] c);
    int k;
    k = 0;
    @(posedge sys_clk_i);
    #1 k++;
    while (hcnt !== c && k < 40) begin
      @(posedge sys_clk_i);
      #1 k++;
    end
    if (k >= 40) begin
      error_cnt++;
      $display("[ERR] column expected %h seen none", c);
      print_verdict();
    end
  endtask

  // Counts displayed, blanked and sync lines over one frame
  task automatic meas(input int n, input int ed, input int eb, input int es);
    int d, b, s;
    d = 0;
    b = 0;
    s = 0;
    frame_sync();
    repeat (8) @(posedge sys_clk_i);
    for (int i = 0; i < n; i++) begin
      #1;
      d += (vdisp_o === 1'b1);
      b += (vblank_o === 1'b1);
      s += (vsync_o === 1'b1);
      repeat (16) @(posedge sys_clk_i);
    end
    chk("display lines", d[15:0], ed[15:0]);
    chk("blank lines", b[15:0], eb[15:0]);
    chk("sync lines", s[15:0], es[15:0]);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {reg_wr_i, reg_rd_i, hretrace_i, hdisp_i} = 4'h0;
    {alpha_mode_i, cursor_row_i} = 2'b00;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    hcnt = 4'h0;
    error_cnt = 0;
    n_tests = 0;
    cursor_hits = 0;
    hen = 1'b0;
    rst_i = 1'b1;
    repeat (3) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    #1 chk("display enable at reset", {15'h0, vdisp_o}, 16'h0001);
    chk("irq at reset", {15'h0, irq_o}, 16'h0000);
    for (int a = 12; a <= 23; a++) begin
      rd(a[7:0], rv);
      chk("reset value", {8'h00, rv}, 16'h0000);
    end
    // Reserved bits ignore writes and read zero
    for (int i = 0; i < 3; i++) begin
      wr(RSV_OFS[i], 8'hFF);
      rd(RSV_OFS[i], rv);
      chk("reserved bits", {8'h00, rv}, {8'h00, RSV_MASK[i]});
      wr(RSV_OFS[i], 8'h00);
    end
    wr(8'h30, 8'hFF);
    rd(8'h30, rv);
    chk("unmapped read", {8'h00, rv}, 16'h0000);
    // Protected overflow keeps only the line compare bit writable
    wr(OFS_VSYNC_END, 8'h80);
    wr(OFS_OVERFLOW, 8'hFF);
    rd(OFS_OVERFLOW, rv);
    chk("protected write", {8'h00, rv}, 16'h0010);
    wr(OFS_VSYNC_END, 8'h00);
    wr(OFS_OVERFLOW, 8'hFF);
    rd(OFS_OVERFLOW, rv);
    chk("unprotected write", {8'h00, rv}, 16'h00FF);
    wr(OFS_OVERFLOW, 8'h00);
    // Start address a multiple of 8, so legal in every configuration
    wr(OFS_START_MID, 8'h65);
    wr(OFS_START_LOW, 8'h38);
    foreach (MAPS[i]) begin
      wr(OFS_UNDERLINE, MAPS[i][31:24]);
      wr(OFS_MODE_CTRL, MAPS[i][23:16]);
      repeat (40) @(posedge sys_clk_i);
      #1 chk("refresh address", mem_addr_o, MAPS[i][15:0]);
      chk("fetched address", fetch_addr, MAPS[i][15:0]);
    end
    wr(OFS_UNDERLINE, 8'h00);
    foreach (FRAME_CFG[i]) begin
      wr(FRAME_CFG[i][15:8], FRAME_CFG[i][7:0]);
    end
    meas(10, 5, 2, 1);
    chk("irq after sync", {15'h0, irq_o}, 16'h0001);
    wr(OFS_VSYNC_END, 8'h28);
    repeat (2) @(posedge sys_clk_i);
    #1 chk("irq cleared", {15'h0, irq_o}, 16'h0000);
    wr(OFS_VSYNC_END, 8'h18);
    repeat (200) @(posedge sys_clk_i);
    #1 chk("irq disabled", {15'h0, irq_o}, 16'h0000);
    wr(OFS_VSYNC_END, 8'h38);
    repeat (2) @(posedge sys_clk_i);
    #1 chk("irq on enable", {15'h0, irq_o}, 16'h0001);
    // Cursor sits on column 8 of line 0, but graphics mode hides it
    wr(OFS_CURSOR_HIGH, 8'h65);
    wr(OFS_CURSOR_LOW, 8'h3C);
    cursor_row_i <= 1'b1;
    hen <= 1'b1;
    // Vertical counter on every second retrace doubles each span
    wr(OFS_MODE_CTRL, 8'h47);
    meas(20, 10, 4, 2);
    chk("cursor outside text", cursor_hits[15:0], 16'h0000);
    // Row step, counter divider and underline over two lines
    wr(OFS_LINE_OFFSET, 8'h10);
    foreach (HROWS[i]) begin
      wr(OFS_UNDERLINE, HROWS[i][47:40]);
      wr(OFS_MODE_CTRL, HROWS[i][39:32]);
      frame_sync();
      at_col(4'h8);
      chk("underline", {15'h0, underline_o},
        {15'h0, HROWS[i][44:40] == 5'h00});
      at_col(4'hE);
      chk("line 0 address", mem_addr_o, HROWS[i][31:16]);
      at_col(4'hE);
      chk("line 1 address", mem_addr_o, HROWS[i][15:0]);
    end
    // Skew moves the cursor right; the last pass leaves text mode
    for (int s = 0; s < 5; s++) begin
      alpha_mode_i <= (s < 4);
      wr(OFS_CURSOR_END, {1'b0, s[1:0], 5'h00});
      frame_sync();
      at_col(4'(8 + s[1:0]));
      chk("cursor early", {15'h0, cursor_o}, 16'h0000);
      at_col(4'(9 + s[1:0]));
      chk("cursor skew", {15'h0, cursor_o}, {15'h0, s < 4});
    end
    // Reset in mid-frame returns the block to its idle state
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    #1 chk("display enable after reset", {15'h0, vdisp_o}, 16'h0001);
    chk("irq after reset", {15'h0, irq_o}, 16'h0000);
    rd(OFS_VSYNC_END, rv);
    chk("control after reset", {8'h00, rv}, 16'h0000);
    print_verdict();
  end
endmodule // crtcv_core_bench

/* verif/crtcv_mem_model.sv */
// Purpose: Display memory controller model taking refresh addresses
// Assumes: One refresh address presented per character clock
// Notes: Latches each address a cycle late, as a fetch queue would
module crtcv_mem_model (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [15:0] mem_addr_i,
  output logic [15:0] fetch_addr_o
);
  logic [15:0] next_fetch_addr;

  ////////////////////////////////////////////////////////////////////////////
  // No back-pressure: the refresh stream never waits on memory
  always_comb begin
    next_fetch_addr = mem_addr_i;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      fetch_addr_o <= 16'h0000;
    end else begin
      fetch_addr_o <= next_fetch_addr;
    end
  end
endmodule // crtcv_mem_model
